// [pkg/loop_pkg.sv]
// constants, types and helpers shared by the loop control design
package loop_pkg;
    localparam int LOOPS = 2;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int FEEDBACK_DIV_SELECT_W = 5;
    localparam int PSEL_W = 2;
    localparam int CRIT_W = 4;
    localparam int PCNT_W = 4;
    localparam int RUN_W = 4;
    localparam int ERR_W = 8;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_CTRL_BASE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CTRL_STRIDE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CRIT = 4'hC;

    // loop_control_reg field positions
    localparam int F_FEEDBACK_DIV_SELECT_LO = 0;
    localparam int F_PSEL_LO = 5;
    localparam int F_BYPASS = 7;
    localparam int F_PD = 8;
    // status field positions
    localparam int F_ST_LOCK_LO = 0;
    localparam int F_ST_PD_LO = 2;

    // values after reset
    localparam logic [FEEDBACK_DIV_SELECT_W-1:0] RST_FEEDBACK_DIV_SELECT = 5'h00;
    localparam logic [PSEL_W-1:0] RST_PSEL = 2'h0;
    localparam logic RST_BYPASS = 1'b0;
    localparam logic RST_PD = 1'b1;
    localparam logic [CRIT_W-1:0] RST_CRIT = 4'h2;

    // lock needs more than this many good measurements in a row
    localparam logic [RUN_W-1:0] LOCK_RUN = 4'h8;

    typedef enum logic [1:0] {
        DET_OFF = 2'b00,
        DET_ARMED = 2'b01,
        DET_WAIT = 2'b11
    } det_state_t;

    function automatic logic rise(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction

    // post divider P from the select field: 1, 2, 4, 8
    function automatic logic [PCNT_W-1:0] post_ratio(input logic [PSEL_W-1:0] psel);
        return 4'h1 << psel;
    endfunction

    function automatic logic [ADDR_W-1:0] ctrl_addr(input int idx);
        return OFS_CTRL_BASE + ADDR_W'(idx * 4);
    endfunction
endpackage

// [pkg/loop_if.sv]
// per-loop signals between the control core and its dividers
`timescale 1ns/1ps
interface loop_if;
    logic [loop_pkg::FEEDBACK_DIV_SELECT_W-1:0] m_sel;
    logic [loop_pkg::PSEL_W-1:0] p_sel;
    logic bypass;
    logic powerdown;
    logic out_edge;
    logic fb_edge;

    modport ctrl (output m_sel, output p_sel, output bypass, output powerdown,
                  input fb_edge);
    modport post (input p_sel, input bypass, input powerdown, output out_edge);
    modport fbdiv (input m_sel, input powerdown, input out_edge, output fb_edge);
endinterface

// [hdl/post_divider.sv]
// post divider: oscillator divided by 2P, or bypassed straight through
`timescale 1ns/1ps
module post_divider
    import loop_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic osc_clk_in,
    loop_if.post lp,
    output logic clk_out
);
    logic osc_q, osc_d;
    logic [PCNT_W-1:0] cnt_q, cnt_d;
    logic out_q, out_d;
    logic edge_q, edge_d;

    // half period is P oscillator edges, so the output is 50% duty
    always_comb begin
        osc_d = osc_clk_in;
        cnt_d = cnt_q;
        out_d = out_q;
        edge_d = 1'b0;
        if (lp.powerdown) begin
            cnt_d = '0;
            out_d = 1'b0;
        end else if (lp.bypass) begin
            out_d = osc_clk_in;
            edge_d = rise(osc_q, osc_clk_in);
        end else if (rise(osc_q, osc_clk_in)) begin
            if (cnt_q == post_ratio(lp.p_sel) - 4'h1) begin
                cnt_d = '0;
                out_d = ~out_q;
                edge_d = ~out_q;
            end else begin
                cnt_d = cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            osc_q <= 1'b0;
            cnt_q <= '0;
            out_q <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            osc_q <= osc_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            edge_q <= edge_d;
        end
    end

    assign lp.out_edge = edge_q;
    assign clk_out = out_q;
endmodule

// [hdl/feedback_divider.sv]
// feedback divider: output clock divided by M = select + 1
`timescale 1ns/1ps
module feedback_divider
    import loop_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    loop_if.fbdiv lp,
    output logic fb_clk
);
    logic [FEEDBACK_DIV_SELECT_W-1:0] cnt_q, cnt_d;
    logic fb_q, fb_d;
    logic edge_q, edge_d;

    // counts 0..select, so the ratio is select plus one
    always_comb begin
        cnt_d = cnt_q;
        fb_d = fb_q;
        edge_d = 1'b0;
        if (lp.powerdown) begin
            cnt_d = '0;
            fb_d = 1'b0;
        end else if (lp.out_edge) begin
            if (cnt_q == lp.m_sel) begin
                cnt_d = '0;
                edge_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 5'h01;
            end
            fb_d = (cnt_d == '0);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
            fb_q <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            fb_q <= fb_d;
            edge_q <= edge_d;
        end
    end

    assign lp.fb_edge = edge_q;
    assign fb_clk = fb_q;
endmodule

// [hdl/pll_lock_and_divider_control.sv]
// loop control: registers, lock detectors and two divider chains
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module pll_lock_and_divider_control
    import loop_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [loop_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [loop_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [loop_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [loop_pkg::LOOPS-1:0] ref_clk_in,
    input wire logic [loop_pkg::LOOPS-1:0] osc_clk_in,
    output logic [loop_pkg::LOOPS-1:0] osc_run,
    output logic [loop_pkg::LOOPS-1:0] div_reset,
    output logic [loop_pkg::LOOPS-1:0] loop_output_clock,
    output logic [loop_pkg::LOOPS-1:0] feedback_clock,
    output logic [loop_pkg::LOOPS-1:0] loop_locked
);
    import loop_pkg::*;

    // control register state, one set per loop apart from the shared criterion
    logic [FEEDBACK_DIV_SELECT_W-1:0] feedback_div_select_q [LOOPS];
    logic [FEEDBACK_DIV_SELECT_W-1:0] feedback_div_select_d [LOOPS];
    logic [PSEL_W-1:0] psel_q [LOOPS];
    logic [PSEL_W-1:0] psel_d [LOOPS];
    logic [LOOPS-1:0] bypass_q, bypass_d;
    logic [LOOPS-1:0] pd_q, pd_d;
    // one criterion serves both loops, which keeps the map small
    logic [CRIT_W-1:0] crit_q, crit_d;

    // pins that follow power-down, registered so outputs come from flops
    logic [LOOPS-1:0] osc_run_q, osc_run_d;
    logic [LOOPS-1:0] div_reset_q, div_reset_d;

    // lock status towards software
    logic [LOOPS-1:0] lock_w;
    logic [LOOPS-1:0] lock_meta_q, lock_meta_d;
    logic [LOOPS-1:0] lock_sync_q, lock_sync_d;

    logic [DATA_W-1:0] rdata_q, rdata_d;

    // register writes; a write to a divider field takes effect at once,
    // so software is expected to hold the loop in power-down meanwhile,
    // and a write to an unmapped offset leaves every field as it was
    always_comb begin
        feedback_div_select_d = feedback_div_select_q;
        psel_d = psel_q;
        bypass_d = bypass_q;
        pd_d = pd_q;
        crit_d = crit_q;
        if (reg_wr) begin
            for (int i = 0; i < LOOPS; i++) begin
                if (reg_addr == ctrl_addr(i)) begin
                    feedback_div_select_d[i] = reg_wdata[F_FEEDBACK_DIV_SELECT_LO +: FEEDBACK_DIV_SELECT_W];
                    psel_d[i] = reg_wdata[F_PSEL_LO +: PSEL_W];
                    bypass_d[i] = reg_wdata[F_BYPASS];
                    pd_d[i] = reg_wdata[F_PD];
                end
            end
            if (reg_addr == OFS_CRIT) begin
                crit_d = reg_wdata[CRIT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < LOOPS; i++) begin
                feedback_div_select_q[i] <= RST_FEEDBACK_DIV_SELECT;
                psel_q[i] <= RST_PSEL;
            end
            bypass_q <= {LOOPS{RST_BYPASS}};
            pd_q <= {LOOPS{RST_PD}};
            crit_q <= RST_CRIT;
        end else begin
            feedback_div_select_q <= feedback_div_select_d;
            psel_q <= psel_d;
            bypass_q <= bypass_d;
            pd_q <= pd_d;
            crit_q <= crit_d;
        end
    end

    // analog enables: oscillator and detector run
    // only out of power-down; divider reset mirrors the control bit
    always_comb begin
        osc_run_d = ~pd_q;
        div_reset_d = pd_q;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            osc_run_q <= '0;
            div_reset_q <= '1;
        end else begin
            osc_run_q <= osc_run_d;
            div_reset_q <= div_reset_d;
        end
    end

    // one chain per loop: index 0 is the system loop, 1 the serial bus
    for (genvar g = 0; g < LOOPS; g++) begin : chain
        loop_if lp ();
        logic ref_q, ref_d;
        det_state_t state_q, state_d;
        logic [ERR_W-1:0] since_fb_q, since_fb_d;
        logic [ERR_W-1:0] timer_q, timer_d;
        logic [RUN_W-1:0] run_q, run_d;
        logic lock_q, lock_d;
        logic ref_rise;
        logic match;
        logic miss;
        logic [ERR_W-1:0] crit_w;

        assign lp.m_sel = feedback_div_select_q[g];
        assign lp.p_sel = psel_q[g];
        assign lp.bypass = bypass_q[g];
        assign lp.powerdown = pd_q[g];
        assign crit_w = ERR_W'(crit_q);

        post_divider u_post (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .osc_clk_in(osc_clk_in[g]),
            .lp(lp.post),
            .clk_out(loop_output_clock[g])
        );

        feedback_divider u_fb (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .lp(lp.fbdiv),
            .fb_clk(feedback_clock[g])
        );

        // phase check: a feedback edge one to crit plus one cycles before or after
        // a reference edge counts as a match, anything else is a miss
        always_comb begin
            ref_d = ref_clk_in[g];
            ref_rise = rise(ref_q, ref_clk_in[g]);
            state_d = state_q;
            timer_d = timer_q;
            run_d = run_q;
            lock_d = lock_q;
            match = 1'b0;
            miss = 1'b0;
            // saturating age of the last feedback edge
            if (lp.fb_edge) begin
                since_fb_d = '0;
            end else if (since_fb_q != '1) begin
                since_fb_d = since_fb_q + 8'h01;
            end else begin
                since_fb_d = since_fb_q;
            end
            case (state_q)
                DET_OFF: begin
                    if (!pd_q[g]) begin
                        state_d = DET_ARMED;
                    end
                end
                DET_ARMED: begin
                    // the age count starts the cycle after the feedback edge, so a
                    // reference trailing by crit plus one cycles still matches
                    if (ref_rise) begin
                        if (since_fb_q <= crit_w) begin
                            match = 1'b1;
                        end else begin
                            state_d = DET_WAIT;
                            timer_d = '0;
                        end
                    end
                end
                DET_WAIT: begin
                    timer_d = timer_q + 8'h01;
                    if (lp.fb_edge && timer_q <= crit_w) begin
                        match = 1'b1;
                        state_d = DET_ARMED;
                    end else if (timer_q >= crit_w || ref_rise) begin
                        miss = 1'b1;
                        state_d = DET_ARMED;
                    end
                end
                default: begin
                    state_d = DET_OFF;
                end
            endcase
            // the run count stops one above the threshold, so it cannot wrap
            // back to zero and drop a held lock by itself
            if (match && run_q <= LOCK_RUN) begin
                run_d = run_q + 4'h1;
            end
            if (run_d > LOCK_RUN) begin
                lock_d = 1'b1;
            end
            if (miss) begin
                run_d = '0;
                lock_d = 1'b0;
            end
            // power-down wins over everything and restarts qualification;
            // parking the age at its ceiling stops a stale feedback edge from
            // matching the first reference edge once power-down ends
            if (pd_q[g]) begin
                state_d = DET_OFF;
                since_fb_d = '1;
                timer_d = '0;
                run_d = '0;
                lock_d = 1'b0;
            end
        end

        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                ref_q <= 1'b0;
                state_q <= DET_OFF;
                since_fb_q <= '1;
                timer_q <= '0;
                run_q <= '0;
                lock_q <= 1'b0;
            end else begin
                ref_q <= ref_d;
                state_q <= state_d;
                since_fb_q <= since_fb_d;
                timer_q <= timer_d;
                run_q <= run_d;
                lock_q <= lock_d;
            end
        end

        assign lock_w[g] = lock_q;
        assign loop_locked[g] = lock_q;
    end

    // two stages keep the status bit steady for software reads
    always_comb begin
        lock_meta_d = lock_w;
        lock_sync_d = lock_meta_q;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lock_meta_q <= '0;
            lock_sync_q <= '0;
        end else begin
            lock_meta_q <= lock_meta_d;
            lock_sync_q <= lock_sync_d;
        end
    end

    // read data stand for one cycle only; unmapped reads return zero
    // status lock bits trail loop_locked by two cycles; the power-down
    // bits are the control bits themselves, not the delayed pins
    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            for (int i = 0; i < LOOPS; i++) begin
                if (reg_addr == ctrl_addr(i)) begin
                    rdata_d[F_FEEDBACK_DIV_SELECT_LO +: FEEDBACK_DIV_SELECT_W] = feedback_div_select_q[i];
                    rdata_d[F_PSEL_LO +: PSEL_W] = psel_q[i];
                    rdata_d[F_BYPASS] = bypass_q[i];
                    rdata_d[F_PD] = pd_q[i];
                end
            end
            if (reg_addr == OFS_STATUS) begin
                rdata_d[F_ST_LOCK_LO +: LOOPS] = lock_sync_q;
                rdata_d[F_ST_PD_LO +: LOOPS] = pd_q;
            end
            if (reg_addr == OFS_CRIT) begin
                rdata_d[CRIT_W-1:0] = crit_q;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign osc_run = osc_run_q;
    assign div_reset = div_reset_q;
endmodule

// [sim/loop_asserts.sv]
// port assertions for the loop control block
`timescale 1ns/1ps
module loop_asserts
    import loop_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [loop_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [loop_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [loop_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [loop_pkg::LOOPS-1:0] ref_clk_in,
    input wire logic [loop_pkg::LOOPS-1:0] osc_run,
    input wire logic [loop_pkg::LOOPS-1:0] div_reset,
    input wire logic [loop_pkg::LOOPS-1:0] feedback_clock,
    input wire logic [loop_pkg::LOOPS-1:0] loop_locked
);
    logic [3:0] refs_q;
    logic [3:0] refs_d;
    logic ref_q;
    // reference rises seen while running and unlocked, saturating
    always_comb begin
        refs_d = refs_q;
        if (!osc_run[0] || loop_locked[0]) begin
            refs_d = 4'h0;
        end else if (ref_clk_in[0] && !ref_q && refs_q != 4'hF) begin
            refs_d = refs_q + 4'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            refs_q <= 4'h0;
            ref_q <= 1'b0;
        end else begin
            refs_q <= refs_d;
            ref_q <= ref_clk_in[0];
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // lock falls in the same cycle that div_reset rises; the check still allows one cycle of slack
    a_pd_lock_low: assert property ((div_reset & $past(div_reset) & loop_locked) == 2'b00)
        else $error("lock high in powerdown");
    a_run_vs_reset: assert property ((osc_run ^ div_reset) == 2'b11
        && (!$changed(osc_run) || $past(reg_wr, 2)))
        else $error("oscillator run disagrees with divider reset or moved alone");
    a_fb_held_pd: assert property ((div_reset & $past(div_reset) & feedback_clock) == 2'b00)
        else $error("feedback clock moves in powerdown");
    a_lock_needs_run: assert property ($rose(loop_locked[0])
        |-> osc_run[0] && $past(osc_run[0], 8))
        else $error("lock without a running loop");
    a_lock_nine_refs: assert property ($rose(loop_locked[0]) |-> refs_q >= 4'h9)
        else $error("lock after too few reference periods");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside its cycle");
    a_pd_sys: assert property (reg_wr && reg_addr == OFS_CTRL_BASE
        |-> ##2 div_reset[0] == $past(reg_wdata[F_PD], 2))
        else $error("system loop powerdown not followed");
    a_pd_ser: assert property (reg_wr && reg_addr == OFS_CTRL_BASE + OFS_CTRL_STRIDE
        |-> ##2 div_reset[1] == $past(reg_wdata[F_PD], 2))
        else $error("serial loop powerdown not followed");
endmodule

// [sim/ref_osc_model.sv]
// reference clock source and oscillator model for both loops
`timescale 1ns/1ps
module ref_osc_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [1:0] osc_run,
    input wire logic [1:0] feedback_clock,
    input wire logic [3:0] lag_sys,
    input wire logic [3:0] lag_ser,
    output logic [1:0] ref_clk_in,
    output logic [1:0] osc_clk_in
);
    logic [15:0] hist_sys;
    logic [15:0] hist_ser;
    logic ph;
    // one fixed oscillator rate of four cycles, legal for any 2P; low while halted
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ph <= 1'b0;
            osc_clk_in <= 2'b00;
            hist_sys <= 16'h0000;
            hist_ser <= 16'h0000;
        end else begin
            ph <= ~ph;
            for (int i = 0; i < 2; i++) begin
                osc_clk_in[i] <= osc_run[i] && (ph ? ~osc_clk_in[i] : osc_clk_in[i]);
            end
            hist_sys <= {hist_sys[14:0], feedback_clock[0]};
            hist_ser <= {hist_ser[14:0], feedback_clock[1]};
        end
    end
    // reference trails feedback by lag cycles; a 16 cycle period is 12.5 MHz
    assign ref_clk_in[0] = hist_sys[lag_sys-4'h1];
    assign ref_clk_in[1] = hist_ser[lag_ser-4'h1];
endmodule

// [sim/tb_top.sv]
// self-checking bench for the loop control block
`timescale 1ns/1ps
module tb_top;
    import loop_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [LOOPS-1:0] ref_in, osc_in, osc_run, div_rst, out_clk, fb_clk, locked;
    logic [3:0] lag_sys = 4'h2;
    logic [3:0] lag_ser = 4'h2;
    logic [DATA_W-1:0] rv;
    logic [ADDR_W-1:0] ra[5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
    logic [DATA_W-1:0] re[5] = '{32'h100, 32'h100, 32'hC, 32'h2, 32'h0};
    int n_fail = 0;
    int cmp_count = 0;
    int hi;
    int lo;
    always #2.5 clk_sys = ~clk_sys;
    pll_lock_and_divider_control i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ref_clk_in(ref_in), .osc_clk_in(osc_in), .osc_run(osc_run),
        .div_reset(div_rst), .loop_output_clock(out_clk), .feedback_clock(fb_clk),
        .loop_locked(locked));
    ref_osc_model i_far (.clk_sys(clk_sys), .reset_n(reset_n), .osc_run(osc_run),
        .feedback_clock(fb_clk), .lag_sys(lag_sys), .lag_ser(lag_ser),
        .ref_clk_in(ref_in), .osc_clk_in(osc_in));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // bus cycles: strobes last one cycle, read data taken in the next
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    // dividers are only retuned with the loop powered down
    task automatic cfg(input int i, input logic [DATA_W-1:0] v);
        wr(i ? 4'h4 : 4'h0, v | 32'h100);
        wr(i ? 4'h4 : 4'h0, v);
    endtask
    task automatic wait_lock(input logic [LOOPS-1:0] want);
        int k;
        for (k = 0; k < 4000 && locked !== want; k++)
            @(negedge clk_sys);
        check("lock", 32'(locked), 32'(want));
        if (k == 4000)
            end_of_test();
    endtask
    function automatic logic sig(input bit f, input int i);
        return f ? fb_clk[i] : out_clk[i];
    endfunction
    // high and low time of one full period, in system cycles
    task automatic meas(input bit f, input int i);
        int k;
        hi = 0;
        lo = 0;
        for (k = 0; k < 600 && sig(f, i) !== 1'b0; k++) @(negedge clk_sys);
        for (k = 0; k < 600 && sig(f, i) !== 1'b1; k++) @(negedge clk_sys);
        for (; hi < 600 && sig(f, i) === 1'b1; hi++) @(negedge clk_sys);
        for (; lo < 600 && sig(f, i) === 1'b0; lo++) @(negedge clk_sys);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        // writes to a hole and to the read-only status must not stick
        wr(4'h2, 32'h3);
        wr(4'h8, 32'h0);
        foreach (ra[j]) begin
            rd(ra[j], rv);
            check("reset read", rv, re[j]);
        end
        check("pd pins", 32'({osc_run, div_rst, locked}), 32'h0C);
        // bring both loops up, M of 2 and P of 1
        cfg(0, 32'h001);
        cfg(1, 32'h001);
        wait_lock(2'b11);
        repeat (4) @(posedge clk_sys);
        rd(4'h8, rv);
        check("status", rv, 32'h3);
        meas(0, 0);
        check("sys post high", hi, 4);
        // every post select, M rising with it
        for (int p = 0; p < 4; p++) begin
            cfg(1, 32'(p) << 5 | 32'(p + 1));
            meas(0, 1);
            check("post high", hi, 4 << p);
            check("post low", lo, 4 << p);
            meas(1, 1);
            check("fb high", hi, 8 << p);
            check("fb period", hi + lo, (p + 2) * (8 << p));
        end
        cfg(1, 32'h081);
        meas(0, 1);
        check("bypass high", hi, 2);
        cfg(1, 32'h001);
        wait_lock(2'b11);
        // reference four cycles late fails a criterion of two
        @(posedge clk_sys);
        lag_sys <= 4'h4;
        wait_lock(2'b10);
        wr(4'hC, 32'h4);
        rd(4'hC, rv);
        check("criterion", rv, 32'h4);
        wait_lock(2'b11);
        // power down the system loop alone, then bring it back
        wr(4'h0, 32'h101);
        repeat (4) @(negedge clk_sys);
        check("pd sys", 32'({osc_run, div_rst, locked}), 32'h26);
        rd(4'h8, rv);
        check("pd status", rv, 32'h6);
        wr(4'h0, 32'h001);
        wait_lock(2'b11);
        end_of_test();
    end
endmodule
bind pll_lock_and_divider_control loop_asserts u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ref_clk_in(ref_clk_in), .osc_run(osc_run),
    .div_reset(div_reset), .feedback_clock(feedback_clock), .loop_locked(loop_locked));
